/* File: i2cv_consts.vh */
// Constants for the I2C voltage-code slave.
// Assumes inclusion by bare name from the design files only.
`ifndef I2CV_CONSTS_VH
`define I2CV_CONSTS_VH

// ==========================================================
// Clock and filter timing
`define I2CV_CLK_NS        5
`define I2CV_SPIKE_NS      50
`define I2CV_SPIKE_CYC     ((`I2CV_SPIKE_NS + `I2CV_CLK_NS - 1) / `I2CV_CLK_NS)

// ==========================================================
// Voltage code register
`define I2CV_CODE_W        6
`define I2CV_CODE_DEFAULT  6'h20
`define I2CV_UV_W          21
`define I2CV_UV_MIN        21'd690000
`define I2CV_UV_STEP       21'd21600
`define I2CV_UV_DEFAULT    21'd1381200

// ==========================================================
// Bus framing
`define I2CV_BYTE_BITS     4'h8
`define I2CV_ADDR_W        7
`define I2CV_ADDR_DEFAULT  7'h2a

`endif

/* File: i2cv_glitch_filter.v */
// Two-stage synchroniser followed by a stability filter for one bus line.
// Assumes the input is asynchronous to SYS_CLK; output changes only after
// the synchronised level has stood steady for more than FILT_CYC cycles.
`timescale 1ns/10ps
module i2cv_glitch_filter #(
  parameter FILT_CYC = 10,
  parameter CNT_W    = 5
) (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);

  reg             meta_q;
  reg             sync_q;
  reg [CNT_W-1:0] cnt_q;

  // ==========================================================
  // Synchroniser and filter
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      cnt_q  <= {CNT_W{1'b0}};
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      if (sync_q == dout) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q == FILT_CYC[CNT_W-1:0]) begin
        // Level held past the spike width
        dout  <= sync_q;
        cnt_q <= {CNT_W{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: i2cv_slave.v */
// Write-only I2C slave holding the six-bit output-voltage code.
// Assumes SCL_I and SDA_I come from open-drain pins outside the SYS_CLK
// domain; the wired level of SDA is resolved from SDA_OE outside.
`timescale 1ns/10ps
`include "i2cv_consts.vh"
module i2cv_slave #(
  parameter [`I2CV_ADDR_W-1:0] DEV_ADDR = `I2CV_ADDR_DEFAULT,
  parameter                    FILT_CYC = `I2CV_SPIKE_CYC
) (
  input  wire                     SYS_CLK,
  input  wire                     RST,
  input  wire                     SCL_I,
  input  wire                     SDA_I,
  output wire                     SDA_O,
  output reg                      SDA_OE,
  output reg  [`I2CV_CODE_W-1:0]  VCODE,
  output reg  [`I2CV_UV_W-1:0]    VTARGET_UV,
  output reg                      VCODE_LOAD,
  output reg                      BUS_ACTIVE
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_ACK_A  = 3'h2;
  localparam [2:0] ST_DATA   = 3'h3;
  localparam [2:0] ST_ACK_D  = 3'h4;
  localparam [2:0] ST_IGNORE = 3'h5;

  // Maps a code to its regulation target in microvolts
  function [`I2CV_UV_W-1:0] code_to_uv;
    input [`I2CV_CODE_W-1:0] code;
    reg   [2*`I2CV_UV_W-1:0] prod;
    begin
      prod       = code * `I2CV_UV_STEP;
      code_to_uv = `I2CV_UV_MIN + prod[`I2CV_UV_W-1:0];
    end
  endfunction

  wire                    scl_f;
  wire                    sda_f;
  reg                     scl_p_q;
  reg                     sda_p_q;
  reg  [2:0]              state_q;
  reg  [3:0]              bit_cnt_q;
  reg  [7:0]              shift_q;
  reg  [`I2CV_CODE_W-1:0] pend_code_q;
  reg                     pend_valid_q;
  reg                     got_byte_q;

  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;
  wire byte_end = scl_fall & (bit_cnt_q == `I2CV_BYTE_BITS);

  // Open-drain: only ever pulls low
  assign SDA_O = 1'b0;

  // ==========================================================
  // Input filtering
  i2cv_glitch_filter #(
    .FILT_CYC (FILT_CYC),
    .CNT_W    (5)
  ) u_scl_filt (
    .clk  (SYS_CLK),
    .rst  (RST),
    .din  (SCL_I),
    .dout (scl_f)
  );

  i2cv_glitch_filter #(
    .FILT_CYC (FILT_CYC),
    .CNT_W    (5)
  ) u_sda_filt (
    .clk  (SYS_CLK),
    .rst  (RST),
    .din  (SDA_I),
    .dout (sda_f)
  );

  // ==========================================================
  // Protocol engine
  always @(posedge SYS_CLK) begin
    if (RST) begin
      scl_p_q      <= 1'b1;
      sda_p_q      <= 1'b1;
      state_q      <= ST_IDLE;
      bit_cnt_q    <= 4'h0;
      shift_q      <= 8'h00;
      pend_code_q  <= `I2CV_CODE_DEFAULT;
      pend_valid_q <= 1'b0;
      got_byte_q   <= 1'b0;
      SDA_OE       <= 1'b0;
      BUS_ACTIVE   <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      if (start_c) begin
        // Repeated START drops any uncommitted byte
        state_q      <= ST_ADDR;
        bit_cnt_q    <= 4'h0;
        pend_valid_q <= 1'b0;
        got_byte_q   <= 1'b0;
        SDA_OE       <= 1'b0;
        BUS_ACTIVE   <= 1'b1;
      end else if (stop_c) begin
        state_q      <= ST_IDLE;
        pend_valid_q <= 1'b0;
        got_byte_q   <= 1'b0;
        SDA_OE       <= 1'b0;
        BUS_ACTIVE   <= 1'b0;
      end else begin
        if (scl_rise && (state_q == ST_ADDR || state_q == ST_DATA)) begin
          shift_q   <= {shift_q[6:0], sda_f};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        case (state_q)
          ST_ADDR: begin
            if (byte_end) begin
              if (shift_q[7:1] == DEV_ADDR && !shift_q[0]) begin
                SDA_OE  <= 1'b1;
                state_q <= ST_ACK_A;
              end else begin
                // Reads and foreign addresses stay unanswered
                state_q <= ST_IGNORE;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              SDA_OE    <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (byte_end) begin
              if (!got_byte_q) begin
                pend_code_q <= shift_q[`I2CV_CODE_W-1:0];
                SDA_OE      <= 1'b1;
                state_q     <= ST_ACK_D;
              end else begin
                // A second data byte voids the transfer
                pend_valid_q <= 1'b0;
                state_q      <= ST_IGNORE;
              end
            end
          end
          ST_ACK_D: begin
            if (scl_fall) begin
              SDA_OE       <= 1'b0;
              pend_valid_q <= 1'b1;
              got_byte_q   <= 1'b1;
              bit_cnt_q    <= 4'h0;
              state_q      <= ST_DATA;
            end
          end
          ST_IGNORE: begin
            SDA_OE <= 1'b0;
          end
          default: begin
            bit_cnt_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Voltage code register
  always @(posedge SYS_CLK) begin
    if (RST) begin
      VCODE      <= `I2CV_CODE_DEFAULT;
      VTARGET_UV <= `I2CV_UV_DEFAULT;
      VCODE_LOAD <= 1'b0;
    end else if (stop_c && pend_valid_q) begin
      VCODE      <= pend_code_q;
      VTARGET_UV <= code_to_uv(pend_code_q);
      VCODE_LOAD <= 1'b1;
    end else begin
      VCODE_LOAD <= 1'b0;
    end
  end

endmodule

/* File: i2cv_master.sv */
// Bus master model for the voltage-code slave.
// Assumes pull-ups: a released line reads high.
`timescale 1ns/10ps
module i2cv_master (
  input  wire sda_in,
  output reg  scl = 1'b1,
  output reg  sda = 1'b1
);
  // ==========================
  // Bit and frame tasks
  task bitx(input b, output s);
    begin
      #20 sda = b;
      #20 scl = 1'b1;
      #20 s = sda_in;
      #20 scl = 1'b0;
    end
  endtask
  task bytex(input [7:0] v, output a);
    integer k;
    reg     s;
    begin
      for (k = 7; k >= 0; k = k - 1) bitx(v[k], s);
      bitx(1'b1, a);
    end
  endtask
  // Two data bytes only when a test asks for it
  task frame(input [7:0] adr, input [7:0] d, input integer n, input fin, output [2:0] ak);
    begin
      ak = 3'b111;
      #40 sda = 1'b0;
      #40 scl = 1'b0;
      bytex(adr, ak[0]);
      bytex(d, ak[1]);
      if (n > 1) bytex(~d, ak[2]);
      if (!fin) begin
        #20 sda = 1'b1;
        #20 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
      end
      #20 sda = 1'b0;
      #20 scl = 1'b1;
      #40 sda = 1'b1;
      #400;
    end
  endtask
  task glitch;
    begin
      #40 sda = 1'b0;
      #10 sda = 1'b1;
      #400;
    end
  endtask
endmodule

/* File: i2cv_slave_chk.sv */
// Concurrent checks on the voltage-code slave ports.
// Assumes binding to i2cv_slave; lines idle high at reset release.
`timescale 1ns/10ps
module i2cv_slave_chk #(
  parameter FILT_CYC = 10
) (
  input wire        SYS_CLK,
  input wire        RST,
  input wire        SCL_I,
  input wire        SDA_I,
  input wire        SDA_O,
  input wire        SDA_OE,
  input wire [5:0]  VCODE,
  input wire [20:0] VTARGET_UV,
  input wire        VCODE_LOAD,
  input wire        BUS_ACTIVE
);
  reg [7:0] low_cnt_q;
  always @(posedge SYS_CLK) begin
    low_cnt_q <= SDA_I ? 8'h00 : (low_cnt_q == 8'hff ? low_cnt_q : low_cnt_q + 8'h01);
  end
  // ==========================
  // Assertions
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  chk_reset_value: assert property (disable iff (1'b0) RST |=> VCODE == 6'h20 &&
    VTARGET_UV == 21'h151350 && !BUS_ACTIVE && !SDA_OE && !VCODE_LOAD) else $error("bad reset");
  chk_load_pulse: assert property (VCODE_LOAD |=> !VCODE_LOAD)
    else $error("commit pulse too long");
  chk_code_hold: assert property (!$past(RST) && VCODE != $past(VCODE) |-> VCODE_LOAD)
    else $error("code changed without commit");
  chk_target_map: assert property (VTARGET_UV == 21'ha8750 + {15'h0, VCODE} * 21'h5460)
    else $error("target mismatch");
  chk_stop_commit: assert property (VCODE_LOAD |-> SCL_I && SDA_I && !BUS_ACTIVE)
    else $error("commit outside stop");
  chk_ack_hold: assert property ($rose(SCL_I) && SDA_OE |-> SDA_OE [*8])
    else $error("ack dropped in clock high");
  chk_pull_only: assert property (SDA_OE |-> SDA_O == 1'b0)
    else $error("data driven high");
  chk_idle_quiet: assert property (!BUS_ACTIVE |-> !SDA_OE)
    else $error("drive outside transfer");
  chk_start_filter: assert property ($rose(BUS_ACTIVE) |-> low_cnt_q >= FILT_CYC)
    else $error("start from short pulse");
  cov_commit: cover property (VCODE_LOAD);
  cov_ack: cover property ($rose(SDA_OE));
  cov_start: cover property ($rose(BUS_ACTIVE));
endmodule
bind i2cv_slave i2cv_slave_chk #(.FILT_CYC(FILT_CYC)) i2cv_slave_chk_i (.SYS_CLK(SYS_CLK),
  .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .VCODE(VCODE),
  .VTARGET_UV(VTARGET_UV), .VCODE_LOAD(VCODE_LOAD), .BUS_ACTIVE(BUS_ACTIVE));

/* File: i2cv_slave_bench.sv */
// Self-checking bench for the voltage-code slave.
// Assumes the master model drives the pins through pull-ups.
`timescale 1ns/10ps
module i2cv_slave_bench;
  localparam FILT = 2;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         scl_q = 1'b1;
  reg         sda_q = 1'b1;
  reg  [5:0]  exp_c = 6'h20;
  reg  [31:0] r;
  integer     fail_count = 0;
  integer     checks_done = 0;
  integer     i;
  wire        sda_o, sda_oe, load, act, m_scl, m_sda;
  wire [5:0]  vcode;
  wire [20:0] vt;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    scl_q <= m_scl;
    sda_q <= m_sda & ~sda_oe;
  end
  i2cv_slave #(.FILT_CYC(FILT)) i2cv_slave_i (.SYS_CLK(clk), .RST(rst), .SCL_I(scl_q),
    .SDA_I(sda_q), .SDA_O(sda_o), .SDA_OE(sda_oe), .VCODE(vcode), .VTARGET_UV(vt),
    .VCODE_LOAD(load), .BUS_ACTIVE(act));
  i2cv_master i2cv_master_i (.sda_in(m_sda & ~sda_oe), .scl(m_scl), .sda(m_sda));
  // ==========================
  // Helpers
  function [20:0] tgt(input [5:0] c);
    tgt = 21'ha8750 + {15'h0, c} * 21'h5460;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task run(input [7:0] a, input [7:0] d, input integer n, input fin, input [2:0] ea);
    reg [2:0] ak;
    begin
      #1.3 i2cv_master_i.frame(a, d, n, fin, ak);
      @(posedge clk);
      check({29'h0, ak}, {29'h0, ea});
      check({26'h0, vcode}, {26'h0, exp_c});
      check({11'h0, vt}, {11'h0, tgt(exp_c)});
      $display("test done addr %h data %h", a, d);
    end
  endtask
  // ==========================
  // Tests
  initial begin
    r = $urandom(32'h72a2b1a3);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({11'h0, vt}, 32'h151350);
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      if (i < 2) r = {32{i[0]}};
      exp_c = r[5:0];
      run(8'h54, r[7:0], 1, 1'b1, 3'b100);
    end
    exp_c = 6'h15;
    run(8'h54, 8'h95, 1, 1'b1, 3'b100);
    run(8'h56, 8'h3a, 1, 1'b1, 3'b111);
    run(8'h55, 8'h3a, 1, 1'b1, 3'b111);
    run(8'h54, 8'h3a, 2, 1'b1, 3'b100);
    run(8'h54, 8'h3a, 1, 1'b0, 3'b100);
    #1.3 i2cv_master_i.glitch;
    check({31'h0, act}, 32'h0);
    @(posedge clk) rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({26'h0, vcode}, 32'h20);
    end_sim;
  end
  // Tests need about 27 us; allow nearly four times that
  initial begin
    #100000;
    fail_count = fail_count + 1;
    end_sim;
  end
endmodule
